// ---- verilog/energy_accum_pkg.sv ----
// Constants, field layouts and carrier types for the energy accumulation stage.
// Assumes a 25 MHz core clock and an Avalon-MM slave with byte addresses.
package energy_accum_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_NOLOAD       = 8'h0E;
   localparam logic [7:0] IDX_ACCUMULATION_MODE      = 8'h0F;
   localparam logic [7:0] IDX_IRQ_STAT     = 8'h10;
   localparam logic [7:0] IDX_IRQ_MASK     = 8'h11;
   localparam logic [7:0] IDX_ACT_ENERGY   = 8'h12;
   localparam logic [7:0] IDX_REACT_ENERGY = 8'h13;
   localparam logic [7:0] IDX_REACT_RST    = 8'h14;
   localparam logic [7:0] IDX_REACT_LINE   = 8'h15;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_NOLOAD  = 8'h00;
   localparam logic [7:0] RST_ACCUMULATION_MODE = 8'h00;
   localparam logic [7:0] RST_STATUS  = 8'h00;
   localparam logic [7:0] ACC_WR_MASK = 8'h7F;   // Bit 7 is a read-only status bit
   localparam int ST_ACT_NL     = 0;
   localparam int ST_REACT_NL   = 1;
   localparam int ST_ACT_SIGN   = 3;
   localparam int ST_REACT_SIGN = 4;
   localparam int ST_FAULT      = 5;
   localparam int PWR_MSB       = 23;

   // ----------------------------------------------------------------
   // No-load thresholds against a full scale of 0x7FFFFF
   // ----------------------------------------------------------------
   localparam logic [1:0]  NL_OFF   = 2'h0;
   localparam logic [1:0]  NL_HIGH  = 2'h1;
   localparam logic [1:0]  NL_MID   = 2'h2;
   localparam logic [24:0] THR_HIGH = 25'h00004EA;  // 0.015% of full scale
   localparam logic [24:0] THR_MID  = 25'h0000275;  // 0.0075% of full scale
   localparam logic [24:0] THR_LOW  = 25'h0000136;  // 0.0037% of full scale

   typedef struct packed {
      logic tamperCurrentChannel;
      logic faultEventSelect;
      logic reactiveSignEventSelect;
      logic activeSignEventSelect;
      logic reactiveAbsoluteAccum;
      logic reactiveSignedByActiveAccum;
      logic activePositiveOnlyAccum;
      logic activeAbsoluteAccum;
   } acc_mode_t;

   typedef struct packed {
      logic [3:0] otherBits;
      logic [1:0] reactiveNoloadThreshold;
      logic [1:0] activeNoloadThreshold;
   } noload_cfg_t;

   typedef struct packed {
      logic signed [23:0] active;
      logic signed [23:0] reactive;
   } power_sample_t;

endpackage

// ---- verilog/energy_accum_mode.sv ----
// Energy accumulation stage: mode register, no-load thresholds, sign and
// fault event flags, energy accumulators and pulse-output feed.
// Assumes power samples, fault mode and tamper channel come from logic on
// core_clk, and that sampleValid marks one accumulation update.
//
// Functional notes
// - Reactive no-load field bits 3:2 sets threshold.
// - Active no-load field bits 1:0 sets threshold.
// - Bit 7 reports tamper current channel, B=1.
// - Bit 6 selects fault entry or exit event.
// - Bit 5 selects reactive sign change direction.
// - Bit 4 selects active sign change direction.
// - Bit 3 accumulates absolute reactive power.
// - Bit 2 inverts reactive when active negative.
// - Signed reactive mode feeds all reactive sinks.
// - Bit 1 accumulates positive active power only.
// - Bit 0 accumulates absolute active power.
// - Selected active sign change sets status bit 3.
// - No-load detection sets status bit 0 or 1.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module energy_accum_mode (
   input  wire logic                          core_clk,      // Core clock, 25 MHz
   input  wire logic                          nrst,          // Async reset, active low
   input  wire logic [7:0]                    address,       // Avalon byte address
   input  wire logic                          read,          // Avalon read request
   input  wire logic                          write,         // Avalon write request
   input  wire logic [31:0]                   writedata,     // Avalon write data
   output var  logic [31:0]                   readdata,      // Avalon read data
   output logic                               waitrequest,   // Avalon stall
   input  wire logic                          sampleValid,   // One accumulation update
   input  wire energy_accum_pkg::power_sample_t powerIn,     // Active and reactive power
   input  wire logic                          faultMode,     // High while in fault mode
   input  wire logic                          tamperChB,     // Current channel B in use
   input  wire logic                          lineCycleEnd,  // End of line-cycle window
   input  wire logic                          cfReactiveSel, // Pulse output follows var
   output var  logic signed [24:0]            cfFeed,        // Pulse output contribution
   output logic                               irq            // Level interrupt
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   energy_accum_pkg::acc_mode_t   accumulation_mode_q;
   energy_accum_pkg::noload_cfg_t noload_q;
   logic [7:0]         status_q;
   logic [7:0]         mask_q;
   logic [31:0]        actEnergy_q;
   logic [31:0]        reactEnergy_q;
   logic [31:0]        reactRst_q;
   logic [31:0]        reactLineAcc_q;
   logic [31:0]        reactLine_q;
   logic               ack_q;
   logic               actSign_q;
   logic               reactSign_q;
   logic               fault_q;
   logic               actNl_q;
   logic               reactNl_q;
   logic               primed_q;

   logic               busReq;
   logic               rdTake;
   logic               wrDone;
   logic [5:0]         wordIdx;
   logic               aligned;
   logic [7:0]         accModeRd;
   logic [7:0]         statusSet;
   logic signed [24:0] actExt;
   logic signed [24:0] reactExt;
   logic [24:0]        actMag;
   logic [24:0]        reactMag;
   logic               actNl;
   logic               reactNl;
   logic signed [24:0] actContrib;
   logic signed [24:0] reactContrib;
   logic               actSign;
   logic               reactSign;

   function automatic logic [24:0] nlThreshold(input logic [1:0] sel);
      if (sel == energy_accum_pkg::NL_HIGH) begin
         return energy_accum_pkg::THR_HIGH;
      end else if (sel == energy_accum_pkg::NL_MID) begin
         return energy_accum_pkg::THR_MID;
      end else begin
         return energy_accum_pkg::THR_LOW;
      end
   endfunction

   function automatic logic [31:0] signExt(input logic signed [24:0] v);
      return {{7{v[24]}}, v};
   endfunction

   // ----------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, answer on the second edge
   // ----------------------------------------------------------------
   assign busReq      = read | write;
   assign waitrequest = busReq & ~ack_q;
   assign rdTake      = read & ~ack_q;
   assign wrDone      = write & ack_q;
   assign wordIdx     = address[7:2];
   assign aligned     = (address[1:0] == 2'h0);
   assign accModeRd   = {tamperChB, accumulation_mode_q[6:0]};

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busReq & ~ack_q;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         readdata <= 32'h0000_0000;
      end else if (rdTake) begin
         if (aligned && wordIdx == energy_accum_pkg::IDX_NOLOAD[5:0]) begin
            readdata <= {24'h000000, noload_q};
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_ACCUMULATION_MODE[5:0]) begin
            readdata <= {24'h000000, accModeRd};
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_IRQ_STAT[5:0]) begin
            readdata <= {24'h000000, status_q};
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_IRQ_MASK[5:0]) begin
            readdata <= {24'h000000, mask_q};
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_ACT_ENERGY[5:0]) begin
            readdata <= actEnergy_q;
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_REACT_ENERGY[5:0]) begin
            readdata <= reactEnergy_q;
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_REACT_RST[5:0]) begin
            readdata <= reactRst_q;
         end else if (aligned && wordIdx == energy_accum_pkg::IDX_REACT_LINE[5:0]) begin
            readdata <= reactLine_q;
         end else begin
            readdata <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accumulation_mode_q <= energy_accum_pkg::RST_ACCUMULATION_MODE;
         noload_q  <= energy_accum_pkg::RST_NOLOAD;
         mask_q    <= energy_accum_pkg::RST_STATUS;
      end else if (wrDone && aligned) begin
         if (wordIdx == energy_accum_pkg::IDX_ACCUMULATION_MODE[5:0]) begin
            accumulation_mode_q <= writedata[7:0] & energy_accum_pkg::ACC_WR_MASK;
         end else if (wordIdx == energy_accum_pkg::IDX_NOLOAD[5:0]) begin
            noload_q <= writedata[7:0];
         end else if (wordIdx == energy_accum_pkg::IDX_IRQ_MASK[5:0]) begin
            mask_q <= writedata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Contribution shaping and no-load detection
   // ----------------------------------------------------------------
   // Widened to 25 bits so negating the most negative sample cannot wrap
   assign actExt    = 25'(powerIn.active);
   assign reactExt  = 25'(powerIn.reactive);
   assign actSign   = powerIn.active[energy_accum_pkg::PWR_MSB];
   assign reactSign = powerIn.reactive[energy_accum_pkg::PWR_MSB];
   assign actMag    = actSign ? 25'(-actExt) : actExt;
   assign reactMag  = reactSign ? 25'(-reactExt) : reactExt;

   assign actNl = (noload_q.activeNoloadThreshold != energy_accum_pkg::NL_OFF)
                && (actMag < nlThreshold(noload_q.activeNoloadThreshold));
   assign reactNl = (noload_q.reactiveNoloadThreshold != energy_accum_pkg::NL_OFF)
                  && (reactMag < nlThreshold(noload_q.reactiveNoloadThreshold));

   always_comb begin
      if (actNl) begin
         actContrib = 25'sh0;
      end else if (accumulation_mode_q.activeAbsoluteAccum) begin
         actContrib = actMag;
      end else if (accumulation_mode_q.activePositiveOnlyAccum) begin
         actContrib = actSign ? 25'sh0 : actExt;
      end else begin
         actContrib = actExt;
      end
   end

   // Absolute mode wins over the active-signed mode when both are set
   always_comb begin
      if (reactNl) begin
         reactContrib = 25'sh0;
      end else if (accumulation_mode_q.reactiveAbsoluteAccum) begin
         reactContrib = reactMag;
      end else if (accumulation_mode_q.reactiveSignedByActiveAccum && actSign) begin
         reactContrib = 25'(-reactExt);
      end else begin
         reactContrib = reactExt;
      end
   end

   // ----------------------------------------------------------------
   // Energy accumulators and pulse feed
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         actEnergy_q    <= 32'h0000_0000;
         reactEnergy_q  <= 32'h0000_0000;
         reactLineAcc_q <= 32'h0000_0000;
         reactLine_q    <= 32'h0000_0000;
         cfFeed         <= 25'sh0;
      end else begin
         if (sampleValid) begin
            actEnergy_q   <= actEnergy_q + signExt(actContrib);
            reactEnergy_q <= reactEnergy_q + signExt(reactContrib);
            cfFeed        <= cfReactiveSel ? reactContrib : actContrib;
         end
         if (lineCycleEnd) begin
            reactLine_q    <= reactLineAcc_q + (sampleValid ? signExt(reactContrib) : 32'h0);
            reactLineAcc_q <= 32'h0000_0000;
         end else if (sampleValid) begin
            reactLineAcc_q <= reactLineAcc_q + signExt(reactContrib);
         end
      end
   end

   // Cleared on the edge that loads readdata, so no sample falls between the two
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reactRst_q <= 32'h0000_0000;
      end else if (rdTake && aligned && wordIdx == energy_accum_pkg::IDX_REACT_RST[5:0]) begin
         reactRst_q <= sampleValid ? signExt(reactContrib) : 32'h0000_0000;
      end else if (sampleValid) begin
         reactRst_q <= reactRst_q + signExt(reactContrib);
      end
   end

   // ----------------------------------------------------------------
   // Transition detection against the previous update
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         actSign_q   <= 1'b0;
         reactSign_q <= 1'b0;
         fault_q     <= 1'b0;
         actNl_q     <= 1'b0;
         reactNl_q   <= 1'b0;
         primed_q    <= 1'b0;
      end else if (sampleValid) begin
         actSign_q   <= actSign;
         reactSign_q <= reactSign;
         fault_q     <= faultMode;
         actNl_q     <= actNl;
         reactNl_q   <= reactNl;
         primed_q    <= 1'b1;
      end
   end

   // Event chosen by select bit: 0 = to negative/fault, 1 = to positive/normal
   always_comb begin
      statusSet = 8'h00;
      if (sampleValid && primed_q) begin
         statusSet[energy_accum_pkg::ST_ACT_SIGN] = (actSign != actSign_q)
            && (actSign == ~accumulation_mode_q.activeSignEventSelect);
         statusSet[energy_accum_pkg::ST_REACT_SIGN] = (reactSign != reactSign_q)
            && (reactSign == ~accumulation_mode_q.reactiveSignEventSelect);
         statusSet[energy_accum_pkg::ST_FAULT] = (faultMode != fault_q)
            && (faultMode == ~accumulation_mode_q.faultEventSelect);
      end
      if (sampleValid) begin
         statusSet[energy_accum_pkg::ST_ACT_NL]   = actNl & ~actNl_q;
         statusSet[energy_accum_pkg::ST_REACT_NL] = reactNl & ~reactNl_q;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status: write one to clear, a new event wins
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= energy_accum_pkg::RST_STATUS;
      end else if (wrDone && aligned && wordIdx == energy_accum_pkg::IDX_IRQ_STAT[5:0]) begin
         status_q <= (status_q & ~writedata[7:0]) | statusSet;
      end else begin
         status_q <= status_q | statusSet;
      end
   end

   assign irq = |(status_q & mask_q);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   bus_answer_a: assert property ((read | write) && !ack_q |=> !waitrequest)
      else $error("bus did not answer on second edge");
   chan_report_a: assert property (rdTake && aligned
      && wordIdx == energy_accum_pkg::IDX_ACCUMULATION_MODE[5:0] |=> readdata[7] == $past(tamperChB))
      else $error("channel bit read back does not follow tamper channel");
   act_posonly_a: assert property (!actNl && !accumulation_mode_q.activeAbsoluteAccum
      && accumulation_mode_q.activePositiveOnlyAccum && actSign |-> actContrib == 25'sh0)
      else $error("negative active power accumulated in positive-only mode");
   act_abs_a: assert property (accumulation_mode_q.activeAbsoluteAccum |-> !actContrib[24])
      else $error("absolute active contribution negative");
   react_abs_a: assert property (accumulation_mode_q.reactiveAbsoluteAccum |-> !reactContrib[24])
      else $error("absolute reactive contribution negative");
   react_inv_a: assert property (!reactNl && !accumulation_mode_q.reactiveAbsoluteAccum
      && accumulation_mode_q.reactiveSignedByActiveAccum && actSign |-> reactContrib == -reactExt)
      else $error("reactive not inverted under negative active power");
   act_sign_a: assert property (sampleValid && primed_q && !actSign_q && actSign
      && !accumulation_mode_q.activeSignEventSelect |=> status_q[energy_accum_pkg::ST_ACT_SIGN])
      else $error("active sign flag not set on selected change");
   react_sign_a: assert property (sampleValid && primed_q && !reactSign_q && reactSign
      && !accumulation_mode_q.reactiveSignEventSelect |=> status_q[energy_accum_pkg::ST_REACT_SIGN])
      else $error("reactive sign flag not set on selected change");
   fault_evt_a: assert property (sampleValid && primed_q && fault_q && !faultMode
      && accumulation_mode_q.faultEventSelect |=> status_q[energy_accum_pkg::ST_FAULT])
      else $error("fault flag not set on return to normal mode");
   single_evt_a: assert property (sampleValid && actSign == actSign_q
      |-> !statusSet[energy_accum_pkg::ST_ACT_SIGN])
      else $error("sign flag set without a sign change");
   noload_flag_a: assert property (sampleValid && actNl && !actNl_q
      |=> status_q[energy_accum_pkg::ST_ACT_NL])
      else $error("active no-load flag not set");
   noload_thr_a: assert property (!accumulation_mode_q.reactiveAbsoluteAccum
      && !accumulation_mode_q.reactiveSignedByActiveAccum
      && noload_q.reactiveNoloadThreshold == energy_accum_pkg::NL_OFF
      |-> reactContrib == reactExt)
      else $error("reactive power dropped while no-load detection disabled");
   irq_clear_a: assert property (wrDone && aligned && !sampleValid
      && wordIdx == energy_accum_pkg::IDX_IRQ_STAT[5:0] && writedata[7:0] == 8'hFF |=> !irq)
      else $error("interrupt still raised after all flags cleared");

endmodule
`default_nettype wire

// ---- testbench/tb_energy_accum_mode.sv ----
// Self-checking bench for the energy accumulation stage.
// Assumes the design answers every Avalon access after one wait cycle and
// that power samples are single-cycle pulses on the core clock.
`timescale 1ns/10ps
`default_nettype none
module tb_energy_accum_mode;
   // ----------------------------------------------------------------
   // Signals and model state
   // ----------------------------------------------------------------
   typedef struct {
      logic [7:0] mode;
      int         act;
      int         react;
      logic       flt;
      logic       cf;
      logic [7:0] st;
   } step_t;
   logic                           core_clk = 1'b0;
   logic                           nrst = 1'b0;
   logic [7:0]                     address = 8'h00;
   logic                           read = 1'b0;
   logic                           write = 1'b0;
   logic [31:0]                    writedata = 32'h00000000;
   logic [31:0]                    readdata;
   logic                           waitrequest;
   logic                           sampleValid = 1'b0;
   energy_accum_pkg::power_sample_t powerIn = '0;
   logic                           faultMode = 1'b0;
   logic                           tamperChB = 1'b0;
   logic                           lineCycleEnd = 1'b0;
   logic                           cfReactiveSel = 1'b0;
   logic signed [24:0]             cfFeed;
   logic                           irq;
   int                             errors = 0;
   int                             num_checks = 0;
   int                             cycles = 0;
   int                             actE = 0;
   int                             reE = 0;
   int                             rstE = 0;
   int                             lineE = 0;
   logic [7:0]                     modeV = 8'h00;
   logic [7:0]                     nlV = 8'h00;
   logic [31:0]                    rd;
   int                             thr [4] = '{0, 1258, 629, 310};
   // Every row is preceded by a clean status, so st is the flag set of that update alone
   step_t steps [12] = '{
      '{8'h00, 4096, 4096, 1'b0, 1'b0, 8'h00}, '{8'h00, -4096, 3000, 1'b0, 1'b1, 8'h08},
      '{8'h00, -2000, -4096, 1'b0, 1'b0, 8'h10}, '{8'h00, -4096, -5000, 1'b1, 1'b1, 8'h20},
      '{8'h70, 6000, 4096, 1'b0, 1'b0, 8'h38}, '{8'h70, -4096, -2500, 1'b1, 1'b1, 8'h00},
      '{8'h01, -7000, 4096, 1'b1, 1'b0, 8'h00}, '{8'h02, -4096, 3500, 1'b1, 1'b0, 8'h00},
      '{8'h08, 5000, -4096, 1'b0, 1'b1, 8'h10}, '{8'h04, -4096, 3000, 1'b0, 1'b1, 8'h08},
      '{8'h0C, -3000, -4096, 1'b0, 1'b1, 8'h10}, '{8'h03, -4096, -2000, 1'b0, 1'b0, 8'h00}};

   energy_accum_mode dut (
      .core_clk      (core_clk),
      .nrst          (nrst),
      .address       (address),
      .read          (read),
      .write         (write),
      .writedata     (writedata),
      .readdata      (readdata),
      .waitrequest   (waitrequest),
      .sampleValid   (sampleValid),
      .powerIn       (powerIn),
      .faultMode     (faultMode),
      .tamperChB     (tamperChB),
      .lineCycleEnd  (lineCycleEnd),
      .cfReactiveSel (cfReactiveSel),
      .cfFeed        (cfFeed),
      .irq           (irq)
   );

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // Reference arithmetic and bus tasks
   // ----------------------------------------------------------------
   function automatic int mag(int v);
      return (v < 0) ? -v : v;
   endfunction

   function automatic int actC(int a, logic [7:0] m, logic [1:0] nl);
      if (nl != 2'h0 && mag(a) < thr[nl]) return 0;
      if (m[0]) return mag(a);
      if (m[1] && a < 0) return 0;
      return a;
   endfunction

   function automatic int reactC(int r, int a, logic [7:0] m, logic [1:0] nl);
      if (nl != 2'h0 && mag(r) < thr[nl]) return 0;
      if (m[3]) return mag(r);
      if (m[2] && a < 0) return -r;
      return r;
   endfunction

   task automatic end_of_test();
      if (errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chkReg(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkBit(logic got, logic exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request is held until the edge where waitrequest is seen low
   task automatic avAccess(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic avWrite(logic [7:0] a, logic [31:0] d);
      logic [31:0] unused;
      avAccess(1'b1, a, d, unused);
   endtask

   task automatic avCheck(logic [7:0] a, logic [31:0] exp);
      avAccess(1'b0, a, 32'h00000000, rd);
      chkReg(rd, exp);
   endtask

   task automatic sample(int a, int r, logic f, logic cf);
      int ca;
      int cr;
      ca = actC(a, modeV, nlV[1:0]);
      cr = reactC(r, a, modeV, nlV[3:2]);
      sampleValid <= 1'b1;
      powerIn <= {a[23:0], r[23:0]};
      faultMode <= f;
      cfReactiveSel <= cf;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      @(posedge core_clk);
      actE += ca;
      reE += cr;
      rstE += cr;
      lineE += cr;
      chkReg(32'(cfFeed), cf ? cr : ca);
   endtask

   // ----------------------------------------------------------------
   // Timeout and main sequence
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      tamperChB <= 1'b1;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      avCheck(8'h38, 32'h00000000);
      avCheck(8'h3C, 32'h00000080);
      avCheck(8'h40, 32'h00000000);
      avCheck(8'h44, 32'h00000000);
      avWrite(8'h3C, 32'h000000FF);
      avCheck(8'h3C, 32'h000000FF);
      tamperChB <= 1'b0;
      avCheck(8'h3C, 32'h0000007F);
      avWrite(8'h39, 32'h000000AA);
      avWrite(8'h38, 32'h0000000F);
      avCheck(8'h38, 32'h0000000F);
      avWrite(8'h38, 32'h00000000);
      avCheck(8'h80, 32'h00000000);
      avWrite(8'h44, 32'h00000018);
      avCheck(8'h44, 32'h00000018);
      // Table walks every mode bit and both directions of every event select
      foreach (steps[i]) begin
         modeV = steps[i].mode;
         avWrite(8'h3C, {24'h000000, modeV});
         sample(steps[i].act, steps[i].react, steps[i].flt, steps[i].cf);
         avCheck(8'h40, {24'h000000, steps[i].st});
         chkBit(irq, (steps[i].st & 8'h18) != 8'h00);
         avWrite(8'h40, 32'h000000FF);
         chkBit(irq, 1'b0);
      end
      modeV = 8'h00;
      avWrite(8'h3C, 32'h00000000);
      lineCycleEnd <= 1'b1;
      @(posedge core_clk);
      lineCycleEnd <= 1'b0;
      @(posedge core_clk);
      avCheck(8'h54, lineE);
      // Power exactly at the threshold accumulates, one count below it does not
      for (int c = 1; c < 4; c++) begin
         nlV = {4'h0, c[1:0], c[1:0]};
         avWrite(8'h38, {24'h000000, nlV});
         sample(thr[c], thr[c], 1'b0, 1'b0);
         avWrite(8'h40, 32'h000000FF);
         sample(thr[c] - 1, thr[c] - 1, 1'b0, 1'b1);
         avCheck(8'h40, 32'h00000003);
         avCheck(8'h48, actE);
      end
      avCheck(8'h48, actE);
      avCheck(8'h4C, reE);
      avCheck(8'h50, rstE);
      avCheck(8'h50, 32'h00000000);
      end_of_test();
   end
endmodule
`default_nettype wire
